// ===== sim/tcr_host.sv
module tcr_host (
  // apb
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic err = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    // upper half of the word unused, kept zero
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tcr_host

// ===== sim/tcr_properties.sv
`include "tcr_defs.svh"
module tcr_properties (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // events and controls
  input wire logic supply_por_trip,
  input wire logic shutdown_done,
  input wire tcr_pkg::tcr_ctrl_t ctrl,
  input wire tcr_pkg::tcr_chan_t chan,
  input wire logic comm_counter_reset,
  input wire logic shutdown_request
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic tw = psel && penable && paddr == `TCR_ADDR_TEST_CONFIG;
  // five quiet cycles cover the two-flop sync, the arm register and the output stage
  sequence no_done; !shutdown_done [*5]; endsequence
  a_rsvd_read: assert property (tw && !pwrite |-> (prdata & 32'hfffff02a) == 32'h0)
    else $error("reserved bits read nonzero");
  a_hold_count: assert property (ctrl.comm_counter_hold && $past(ctrl.comm_counter_hold) |-> !comm_counter_reset)
    else $error("counter reset under hold");
  a_trip_shut: assert property (supply_por_trip && ctrl.digital_supply_reset_test |-> ##[1:4] shutdown_request)
    else $error("no shutdown on trip");
  a_arm_sticky: assert property ((no_done ##0 ctrl.digital_supply_reset_test) |=> ctrl.digital_supply_reset_test)
    else $error("arm dropped early");
  a_bleed_route: assert property ($stable(ctrl.open_wire_bleed_select) && ctrl.open_wire_bleed_select |-> chan.balance_out == 16'h0)
    else $error("balance on in bleed mode");
  a_bal_route: assert property ($stable(ctrl.open_wire_bleed_select) && !ctrl.open_wire_bleed_select |-> chan.bleed_out == 16'h0)
    else $error("bleed on in balance mode");
  a_pump_bit: assert property (tw && pwrite |=> ##1 ctrl.negative_pump_monitor_enable == $past(pwdata[2], 2))
    else $error("pump monitor bit wrong");
  a_module_bit: assert property (tw && pwrite |=> ##1 ctrl.module_voltage_monitor_enable == $past(pwdata[0], 2))
    else $error("module monitor bit wrong");
  c_tw: cover property (tw && pwrite);
  c_shut: cover property ($rose(shutdown_request));
  c_cnt: cover property ($rose(comm_counter_reset));
endmodule : tcr_properties

// ===== sim/tcr_test_config_bench.sv
`include "tcr_defs.svh"
module tcr_test_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import tcr_pkg::*;
  logic pclk = 0, presetn = 0, valid_packet = 0, supply_por_trip = 0, fault_any = 0, custom_checksum_error = 0;
  logic shutdown_done = 0, psel, penable, pwrite, pready, pslverr, comm_counter_reset, shutdown_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  tcr_ctrl_t ctrl;
  tcr_chan_t chan;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  tcr_host i_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  tcr_test_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .valid_packet(valid_packet), .supply_por_trip(supply_por_trip), .fault_any(fault_any),
    .custom_checksum_error(custom_checksum_error), .shutdown_done(shutdown_done), .ctrl(ctrl), .chan(chan),
    .comm_counter_reset(comm_counter_reset), .shutdown_request(shutdown_request));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    i_host.xfer(0, `TCR_ADDR_TEST_CONFIG, 0, d); chk("tcr reset", `TCR_TEST_RST, d);
    i_host.xfer(1, `TCR_ADDR_TEST_CONFIG, 16'hffd5, d);
    i_host.xfer(0, `TCR_ADDR_TEST_CONFIG, 0, d); chk("tcr mask", {16'h0000, `TCR_IMPL_MASK}, d);
    chk("ctrl", 32'h1ff, ctrl);
    // power-down period is never written while hold is set
    valid_packet <= 1'b1;
    repeat (5) @(posedge pclk); chk("held reset", 0, comm_counter_reset);
    i_host.xfer(1, `TCR_ADDR_TEST_CONFIG, 16'h0000, d);
    repeat (5) @(posedge pclk); chk("free reset", 1, comm_counter_reset);
    i_host.xfer(0, `TCR_ADDR_TEST_CONFIG, 0, d); chk("vdig read", 0, d);
    chk("armed", 1, ctrl.digital_supply_reset_test);
    supply_por_trip <= 1'b1;
    repeat (5) @(posedge pclk); chk("shutdown", 1, shutdown_request);
    shutdown_done <= 1'b1;
    supply_por_trip <= 1'b0;
    repeat (6) @(posedge pclk); chk("disarmed", 0, ctrl.digital_supply_reset_test);
    i_host.xfer(1, `TCR_ADDR_BAL_CONFIG, 16'h0008, d);
    i_host.xfer(1, `TCR_ADDR_TEST_CONFIG, 16'h0010, d);
    i_host.xfer(1, `TCR_ADDR_BAL_ENABLE, 16'h00a5, d);
    repeat (3) @(posedge pclk); chk("bleed", 32'ha5, chan.bleed_out);
    chk("bal off", 0, chan.balance_out);
    i_host.xfer(1, `TCR_ADDR_TEST_CONFIG, 16'h0000, d);
    repeat (3) @(posedge pclk); chk("bal on", 32'ha5, chan.balance_out);
    i_host.xfer(1, `TCR_ADDR_BAL_CONFIG, 16'h0000, d);
    custom_checksum_error <= 1'b1;
    repeat (5) @(posedge pclk);
    i_host.xfer(0, `TCR_ADDR_BAL_ENABLE, 0, d); chk("cksum kept", 32'ha5, d);
    fault_any <= 1'b1;
    repeat (5) @(posedge pclk);
    i_host.xfer(1, `TCR_ADDR_BAL_ENABLE, 16'h0003, d);
    i_host.xfer(0, `TCR_ADDR_BAL_ENABLE, 0, d); chk("fault clear", 0, d);
    i_host.xfer(0, `TCR_ADDR_STATUS, 0, d); chk("status", 32'h0000_0019, d);
    chk("no slverr", 0, i_host.err);
    i_host.xfer(0, 12'h004, 0, d); chk("slverr", 1, i_host.err);
    chk("unmapped read", 0, d);
    end_sim();
  end
endmodule : tcr_test_config_bench
bind tcr_test_config tcr_properties i_props (.*);

// ===== src/tcr_defs.svh
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH
// byte addresses on apb (index times four)
`define TCR_IDX_TEST_CONFIG 8'h1e
`define TCR_ADDR_TEST_CONFIG 12'h078
`define TCR_ADDR_BAL_CONFIG 12'h04c
`define TCR_ADDR_BAL_ENABLE 12'h050
`define TCR_ADDR_STATUS 12'h100
// test configuration fields
`define TCR_RSVD_HI_MSB 15
`define TCR_REG_TEST_MSB 11
`define TCR_REG_TEST_LSB 8
`define TCR_HOLD_BIT 7
`define TCR_VDIG_BIT 6
`define TCR_BLEED_BIT 4
`define TCR_PUMP_BIT 2
`define TCR_MODULE_BIT 0
`define TCR_IMPL_MASK 16'h0fd5
// balance configuration field
`define TCR_KEEP_BIT 3
// reset values
`define TCR_TEST_RST 16'h0000
`define TCR_BAL_RST 16'h0000
`endif

// ===== src/tcr_pkg.sv
package tcr_pkg;
  typedef struct packed {
    logic [3:0] regulator_test_field;
    logic comm_counter_hold;
    logic digital_supply_reset_test;
    logic open_wire_bleed_select;
    logic negative_pump_monitor_enable;
    logic module_voltage_monitor_enable;
  } tcr_ctrl_t;
  typedef struct packed {
    logic [15:0] balance_out;
    logic [15:0] bleed_out;
  } tcr_chan_t;
endpackage : tcr_pkg

// ===== src/tcr_test_config.sv
// Operation
// RQ1: bits 15..12 reserved; reads return zero, writes dropped.
// RQ2: regulator test field bits 11..8; host keeps it zero normally.
// RQ3: counter hold bit 7 blocks timeout counter reset on valid packets.
// RQ4: host must not change power-down period while counter hold set.
// RQ5: late power-down write under hold may delay timeout up to 70 minutes.
// RQ6: host recovers by writing a new timeout count before due.
// RQ7: bit 6 set makes digital supply reset trip cause shutdown.
// RQ8: supply reset test stays armed after clear until shutdown; reads 0.
// RQ9: host writes zero to reserved bits 5, 3 and 1.
// RQ10: bleed select bit 4 steers channel enables onto bleed resistors.
// RQ11: bleed select 1 drives bleed resistors, 0 drives balancing outputs.
// RQ12: host should set balance keep-on-fault before using bleed feature.
// RQ13: keep-on-fault 0: any non-checksum fault clears enables, blocks writes.
// RQ14: bit 2 enables negative pump monitor; zero measures its ground.
// RQ15: bit 0 enables module voltage monitor; zero measures its ground.
// RQ16: all implemented bits clear on reset.
`include "tcr_defs.svh"
module tcr_test_config (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device events (pins, asynchronous)
  input wire logic valid_packet,
  input wire logic supply_por_trip,
  input wire logic fault_any,
  input wire logic custom_checksum_error,
  input wire logic shutdown_done,
  // controls out
  output tcr_pkg::tcr_ctrl_t ctrl,
  output tcr_pkg::tcr_chan_t chan,
  output logic comm_counter_reset,
  output logic shutdown_request
);
  import tcr_pkg::*;

  logic [15:0] test_configuration, next_test_configuration;
  logic [15:0] balance_configuration, next_balance_configuration;
  logic [15:0] balance_channel_enable, next_balance_channel_enable;
  logic vdig_armed, next_vdig_armed;
  logic [4:0] sync1, sync2;
  logic [4:0] next_sync1, next_sync2;
  logic [31:0] next_prdata;
  logic next_pslverr, next_pready, next_counter_reset, next_shutdown;
  tcr_ctrl_t next_ctrl;
  tcr_chan_t next_chan;
  logic wr, rd;
  logic pkt, trip, fault, cksum, sdone, fault_block;
  logic sel_test, sel_bal_cfg, sel_bal_en, sel_status;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  // input synchronisers, first stage read only by second
  // pins are levels; a pulse shorter than a clock may be missed
  always_comb begin
    next_sync1 = {valid_packet, supply_por_trip, fault_any, custom_checksum_error, shutdown_done};
    next_sync2 = sync1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // level decode; paddr alone selects, so setup and access see the same selects
  always_comb begin
    // synced levels, two cycles behind the pins
    {pkt, trip, fault, cksum, sdone} = sync2;
    sel_test = hit(paddr, `TCR_ADDR_TEST_CONFIG);
    sel_bal_cfg = hit(paddr, `TCR_ADDR_BAL_CONFIG);
    sel_bal_en = hit(paddr, `TCR_ADDR_BAL_ENABLE);
    sel_status = hit(paddr, `TCR_ADDR_STATUS);
    // zero-wait slave: access phase completes in one cycle
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    // RQ13 fault gating; fault_any carries every fault bit but the checksum error
    fault_block = !balance_configuration[`TCR_KEEP_BIT] && fault;
  end

  // register state
  always_comb begin
    next_test_configuration = test_configuration;
    next_balance_configuration = balance_configuration;
    next_balance_channel_enable = balance_channel_enable;
    next_vdig_armed = vdig_armed;
    // RQ8 bit reads 0 after shutdown; a write in the same cycle still lands
    if (sdone) begin
      next_test_configuration[`TCR_VDIG_BIT] = 1'b0;
    end
    if (wr && sel_test) begin
      // RQ1 reserved bits dropped
      next_test_configuration = pwdata[15:0] & `TCR_IMPL_MASK;
    end
    if (wr && sel_bal_cfg) begin
      // only the timer and keep-on-fault bits exist
      next_balance_configuration = {8'h00, pwdata[7:3], 3'h0};
    end
    // writes dropped while blocked, not held for later
    if (wr && sel_bal_en && !fault_block) begin
      next_balance_channel_enable = pwdata[15:0];
    end
    // RQ13 clear on fault
    if (fault_block) begin
      next_balance_channel_enable = 16'h0000;
    end
    // RQ8 sticky arm until shutdown; set wins over release
    if (sdone) begin
      next_vdig_armed = 1'b0;
    end
    if (test_configuration[`TCR_VDIG_BIT]) begin
      next_vdig_armed = 1'b1;
    end
  end

  // RQ16 reset clears all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_configuration <= `TCR_TEST_RST;
      balance_configuration <= `TCR_BAL_RST;
      balance_channel_enable <= `TCR_BAL_RST;
      vdig_armed <= 1'b0;
    end else begin
      test_configuration <= next_test_configuration;
      balance_configuration <= next_balance_configuration;
      balance_channel_enable <= next_balance_channel_enable;
      vdig_armed <= next_vdig_armed;
    end
  end

  // apb response; error decoded in setup so the registered flag stands in access
  always_comb begin
    next_pready = 1'b1;
    next_pslverr = psel && !penable
      && !(sel_test || sel_bal_cfg || sel_bal_en || sel_status);
    // read data holds until the next read setup
    next_prdata = prdata;
    if (rd) begin
      next_prdata = 32'h0000_0000;
      if (sel_test) begin
        next_prdata = {16'h0000, test_configuration};
      end else if (sel_bal_cfg) begin
        next_prdata = {16'h0000, balance_configuration};
      end else if (sel_bal_en) begin
        next_prdata = {16'h0000, balance_channel_enable};
      end else if (sel_status) begin
        // status: checksum error, fault block, arm, synced trip, synced packet
        next_prdata = {27'h0000000, cksum, fault_block, vdig_armed, trip, pkt};
      end
    end
  end

  // pready low only in reset; every access is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= next_pready;
    end
  end

  // output stage, one cycle behind the registers
  always_comb begin
    // regulator field passes straight out; keeping it zero is up to the host
    next_ctrl.regulator_test_field = test_configuration[`TCR_REG_TEST_MSB:`TCR_REG_TEST_LSB];
    next_ctrl.comm_counter_hold = test_configuration[`TCR_HOLD_BIT];
    // armed state, not the readable bit
    next_ctrl.digital_supply_reset_test = vdig_armed;
    next_ctrl.open_wire_bleed_select = test_configuration[`TCR_BLEED_BIT];
    // RQ14 pump monitor gate
    next_ctrl.negative_pump_monitor_enable = test_configuration[`TCR_PUMP_BIT];
    // RQ15 module monitor gate
    next_ctrl.module_voltage_monitor_enable = test_configuration[`TCR_MODULE_BIT];
    // RQ10 RQ11 steer enables
    if (test_configuration[`TCR_BLEED_BIT]) begin
      next_chan.balance_out = 16'h0000;
      next_chan.bleed_out = balance_channel_enable;
    end else begin
      next_chan.balance_out = balance_channel_enable;
      next_chan.bleed_out = 16'h0000;
    end
    // RQ3 RQ5 hold blocks counter reset; the timeout itself lives outside
    next_counter_reset = pkt && !test_configuration[`TCR_HOLD_BIT];
    // RQ7 shutdown on trip, also in the cycle before the arm registers
    next_shutdown = trip && (vdig_armed || test_configuration[`TCR_VDIG_BIT]);
  end

  // outputs idle in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      chan <= '0;
      comm_counter_reset <= 1'b0;
      shutdown_request <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      chan <= next_chan;
      comm_counter_reset <= next_counter_reset;
      shutdown_request <= next_shutdown;
    end
  end
endmodule : tcr_test_config
